//--- rtl/pmsb_sideband.sv
// Purpose: Power-management sideband between link core and application
// Assumes: One clock mclk (20 MHz), synchronous active-high reset
// Notes:   Link-facing inputs other than linkLowPower (a level) are single-cycle pulses on mclk
`timescale 1ns/1ns
`default_nettype none

// How it works
// - Root role: turnoff control rise sends a turn-off message to link.
// - Endpoint role: turnoff control rise sends the turn-off acknowledge.
// - Root role: status pulses one cycle when acknowledge arrives.
// - Endpoint role: status pulses one cycle when turn-off arrives.
// - Power-event request is ignored in Root role.
// - A power-event rising edge sends one PME message; edges while one is pending merge into it.
// - In low power, wake the link first, then send PME.
// - Report bus used only when all three aux-current bits are zero.
// - Endpoint acknowledge only after the turn-off status pulse.
module pmsb_sideband (
    // Clock and reset
    input  wire logic        mclk,
    input  wire logic        reset,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic             pready,
    output logic [31:0]      prdata,
    output logic             pslverr,
    // Application side
    input  wire logic        turnoffControl,
    input  wire logic        powerEventRequest,
    input  wire logic [9:0]  powerConsumptionReport,
    input  wire logic        auxSupplyIndicator,
    output logic             turnoffStatusPulse,
    output logic             irq,
    // Link side
    input  wire logic        linkTurnoffRx,
    input  wire logic        linkToAckRx,
    input  wire logic        linkLowPower,
    input  wire logic        linkWakeDone,
    output logic             linkWakeReq,
    output logic             msgValid,
    output logic [1:0]       msgKind,
    input  wire logic        msgAccept,
    output logic [7:0]       capDataValue,
    output logic [1:0]       capDataScale
);
    typedef enum {S_IDLE, S_WAKE, S_SEND} pmsb_state_t;

    // Registers and next values
    logic [3:0]  ctrl_reg, ctrl_next;
    logic [pmsb_pkg::IRQ_W-1:0] irqStat_reg, irqStat_next;
    logic [pmsb_pkg::IRQ_W-1:0] irqMask_reg, irqMask_next;
    logic [31:0] prdata_reg, prdata_next;
    logic        pslverr_reg, pslverr_next;
    logic        tocPrev_reg, tocPrev_next;
    logic        pevPrev_reg, pevPrev_next;
    logic        pmePend_reg, pmePend_next;
    logic        toSeen_reg, toSeen_next;
    logic        stPulse_reg, stPulse_next;
    logic [1:0]  msg_reg, msg_next;
    logic [9:0]  report_reg, report_next;
    pmsb_state_t state_reg, state_next;

    logic isRoot, reportEn, tocRise, pevRise, acc, wr, rd;
    logic [pmsb_pkg::IRQ_W-1:0] events;

    // Address decode used by both read and write paths
    function automatic logic hit(input logic [11:0] a, input logic [11:0] off);
        hit = (a == off);
    endfunction : hit

    assign isRoot = ctrl_reg[pmsb_pkg::CTRL_ROOT];
    assign reportEn = (ctrl_reg[pmsb_pkg::CTRL_AUX2:pmsb_pkg::CTRL_AUX0] == 3'h0);
    assign tocRise = turnoffControl & ~tocPrev_reg;
    assign pevRise = powerEventRequest & ~pevPrev_reg;
    assign acc = psel & penable;
    assign wr  = acc & pwrite;
    assign rd  = acc & ~pwrite;
    assign pready = 1'b1;   // Zero wait states
    assign prdata = prdata_reg;
    assign pslverr = pslverr_reg;

    // Event collection for interrupts
    always_comb begin
        events = pmsb_pkg::IRQ_RST;
        events[pmsb_pkg::IRQ_TOFF]  = linkTurnoffRx & ~isRoot;
        events[pmsb_pkg::IRQ_TOACK] = linkToAckRx & isRoot;
        events[pmsb_pkg::IRQ_PME]   = (msg_reg == pmsb_pkg::MSG_PME) & msgAccept;
        events[pmsb_pkg::IRQ_CTRLS] = tocRise;
    end

    // Bus registers; set wins over read-clear
    always_comb begin
        ctrl_next    = ctrl_reg;
        irqMask_next = irqMask_reg;
        irqStat_next = irqStat_reg;
        prdata_next  = pmsb_pkg::ZERO32;
        pslverr_next = 1'b0;
        if (wr && hit(paddr, pmsb_pkg::ADDR_CTRL)) begin
            ctrl_next = pwdata[3:0];
        end
        if (wr && hit(paddr, pmsb_pkg::ADDR_IRQMASK)) begin
            irqMask_next = pwdata[pmsb_pkg::IRQ_W-1:0];
        end
        if (rd && hit(paddr, pmsb_pkg::ADDR_IRQSTAT)) begin
            irqStat_next = pmsb_pkg::IRQ_RST;
        end
        irqStat_next = irqStat_next | events;
        // Decode in the setup cycle so read data stands through the access phase
        if (psel && !penable) begin
            case (paddr)
                pmsb_pkg::ADDR_CTRL:    prdata_next = {28'h0000000, ctrl_reg};
                pmsb_pkg::ADDR_STATUS:  prdata_next = {28'h0000000, reportEn,
                    auxSupplyIndicator, (state_reg != S_IDLE), linkLowPower};
                // Next value, so an event of the setup cycle is read before the clear
                pmsb_pkg::ADDR_IRQSTAT: prdata_next = {28'h0000000, irqStat_next};
                pmsb_pkg::ADDR_IRQMASK: prdata_next = {28'h0000000, irqMask_reg};
                pmsb_pkg::ADDR_REPORT:  prdata_next = {22'h000000, report_reg};
                default:                pslverr_next = 1'b1;
            endcase
        end
    end

    // Read data and error latched at the end of setup: valid at the access edge
    always_ff @(posedge mclk) begin
        if (reset) begin
            ctrl_reg    <= pmsb_pkg::CTRL_RST;
            irqMask_reg <= pmsb_pkg::IRQ_RST;
            irqStat_reg <= pmsb_pkg::IRQ_RST;
            prdata_reg  <= pmsb_pkg::ZERO32;
            pslverr_reg <= 1'b0;
        end else begin
            ctrl_reg    <= ctrl_next;
            irqMask_reg <= irqMask_next;
            irqStat_reg <= irqStat_next;
            prdata_reg  <= prdata_next;
            pslverr_reg <= pslverr_next;
        end
    end

    assign irq = |(irqStat_reg & irqMask_reg);

    // Message sequencer; one message in flight, PME kept pending meanwhile
    always_comb begin
        tocPrev_next = turnoffControl;
        pevPrev_next = powerEventRequest;
        pmePend_next = pmePend_reg;
        toSeen_next  = toSeen_reg;
        msg_next     = msg_reg;
        state_next   = state_reg;
        stPulse_next = 1'b0;
        if (isRoot ? linkToAckRx : linkTurnoffRx) begin
            stPulse_next = 1'b1;
        end
        if (!isRoot && linkTurnoffRx) begin
            toSeen_next = 1'b1;
        end
        // PME edge only in Endpoint role
        if (pevRise && !isRoot) begin
            pmePend_next = 1'b1;
        end
        case (state_reg)
            S_IDLE: begin
                if (tocRise && (isRoot || toSeen_reg)) begin
                    msg_next   = isRoot ? pmsb_pkg::MSG_TURNOFF : pmsb_pkg::MSG_TOACK;
                    toSeen_next = 1'b0;
                    state_next = S_SEND;
                end else if (pmePend_reg) begin
                    // A new edge in this very cycle must stay pending, not be lost
                    pmePend_next = pevRise && !isRoot;
                    msg_next   = pmsb_pkg::MSG_PME;
                    state_next = linkLowPower ? S_WAKE : S_SEND;
                end
            end
            S_WAKE: begin
                if (linkWakeDone) begin
                    state_next = S_SEND;
                end
            end
            S_SEND: begin
                if (msgAccept) begin
                    msg_next   = pmsb_pkg::MSG_NONE;
                    state_next = S_IDLE;
                end
            end
            default: state_next = S_IDLE;
        endcase
        report_next = reportEn ? powerConsumptionReport : {8'h00, pmsb_pkg::SCALE_UNKNOWN};
    end

    // Sequencer registers
    always_ff @(posedge mclk) begin
        if (reset) begin
            tocPrev_reg <= 1'b0;
            pevPrev_reg <= 1'b0;
            pmePend_reg <= 1'b0;
            toSeen_reg  <= 1'b0;
            stPulse_reg <= 1'b0;
            msg_reg     <= pmsb_pkg::MSG_NONE;
            report_reg  <= 10'h000;
            state_reg   <= S_IDLE;
        end else begin
            tocPrev_reg <= tocPrev_next;
            pevPrev_reg <= pevPrev_next;
            pmePend_reg <= pmePend_next;
            toSeen_reg  <= toSeen_next;
            stPulse_reg <= stPulse_next;
            msg_reg     <= msg_next;
            report_reg  <= report_next;
            state_reg   <= state_next;
        end
    end

    // Outputs; aux indicator only reported, L2 never entered
    assign turnoffStatusPulse = stPulse_reg;
    assign msgValid     = (state_reg == S_SEND);
    assign msgKind      = msg_reg;
    assign linkWakeReq  = (state_reg == S_WAKE);
    assign capDataValue = report_reg[pmsb_pkg::RPT_DHI:pmsb_pkg::RPT_DLO];
    assign capDataScale = report_reg[pmsb_pkg::RPT_DLO-1:0];

    sequence s_wake;
        linkWakeReq ##1 linkWakeDone;
    endsequence
    sequence s_pme_send;
        msgValid && msgKind == pmsb_pkg::MSG_PME;
    endsequence

    a_status_root: assert property (@(posedge mclk) disable iff (reset)
        isRoot && linkToAckRx && $stable(isRoot) |=> turnoffStatusPulse ##1
        (!turnoffStatusPulse || $past(linkToAckRx) || $past(linkTurnoffRx)))
        else $error("root status pulse wrong");
    a_status_ep: assert property (@(posedge mclk) disable iff (reset)
        !isRoot && linkTurnoffRx && $stable(isRoot) |=> turnoffStatusPulse)
        else $error("endpoint status pulse missing");
    a_root_turnoff: assert property (@(posedge mclk) disable iff (reset)
        state_reg == S_IDLE && tocRise && isRoot |=> msgValid && msgKind == pmsb_pkg::MSG_TURNOFF)
        else $error("turn-off message not sent");
    a_ep_order: assert property (@(posedge mclk) disable iff (reset)
        msgValid && msgKind == pmsb_pkg::MSG_TOACK && !$past(msgValid) |-> $past(toSeen_reg))
        else $error("ack before turn-off seen");
    a_ep_ack: assert property (@(posedge mclk) disable iff (reset)
        state_reg == S_IDLE && tocRise && !isRoot && toSeen_reg |=> msgKind == pmsb_pkg::MSG_TOACK)
        else $error("acknowledge not sent");
    a_root_nopme: assert property (@(posedge mclk) disable iff (reset)
        isRoot && $stable(isRoot) && pevRise && !pmePend_reg |=> !pmePend_reg)
        else $error("PME accepted in root role");
    a_pme_edge: assert property (@(posedge mclk) disable iff (reset)
        !isRoot && pevRise |=> pmePend_reg || state_reg != S_IDLE)
        else $error("PME edge lost");
    a_wake_first: assert property (@(posedge mclk) disable iff (reset)
        s_wake |=> s_pme_send) else $error("PME not sent after wake");
    a_report_gate: assert property (@(posedge mclk) disable iff (reset)
        !$past(reportEn) |-> capDataValue == 8'h00) else $error("report used while aux set");
    a_single_msg: assert property (@(posedge mclk) disable iff (reset)
        msgValid && msgAccept |=> !msgValid) else $error("message repeated");

    a_wake_hold: assert property (@(posedge mclk) disable iff (reset)
        linkWakeReq && !linkWakeDone |=> linkWakeReq)
        else $error("wake request dropped early");
    a_pulse_cause: assert property (@(posedge mclk) disable iff (reset)
        turnoffStatusPulse |-> $past(linkToAckRx) || $past(linkTurnoffRx))
        else $error("status pulse without cause");
    a_msg_hold: assert property (@(posedge mclk) disable iff (reset)
        msgValid && !msgAccept |=> msgValid && $stable(msgKind))
        else $error("message dropped before accept");
    // Unmasked PME status raises the interrupt
    a_irq_level: assert property (@(posedge mclk) disable iff (reset)
        irqStat_reg[pmsb_pkg::IRQ_PME] && irqMask_reg[pmsb_pkg::IRQ_PME] |-> irq)
        else $error("interrupt not raised");
    // Read data stands in the access phase
    a_read_ctrl: assert property (@(posedge mclk) disable iff (reset)
        psel && !penable && paddr == pmsb_pkg::ADDR_CTRL |=> prdata[3:0] == $past(ctrl_reg))
        else $error("control read data late");
endmodule : pmsb_sideband

`default_nettype wire

//--- rtl/pmsb_pkg.sv
// Purpose: Shared constants for the power-management sideband block
// Assumes: APB slave with 32-bit data, one aligned word per register
// Notes:   All offsets are byte addresses
package pmsb_pkg;
    // Register byte offsets
    localparam logic [11:0] ADDR_CTRL    = 12'h000;
    localparam logic [11:0] ADDR_STATUS  = 12'h004;
    localparam logic [11:0] ADDR_IRQSTAT = 12'h008;
    localparam logic [11:0] ADDR_IRQMASK = 12'h00C;
    localparam logic [11:0] ADDR_REPORT  = 12'h010;
    // Control fields
    localparam int CTRL_ROOT = 0;
    localparam int CTRL_AUX0 = 1;
    localparam int CTRL_AUX2 = 3;
    // Status fields
    localparam int ST_LOWPWR = 0;
    localparam int ST_BUSY   = 1;
    localparam int ST_AUX    = 2;
    localparam int ST_RPTEN  = 3;
    // Interrupt bits
    localparam int IRQ_W     = 4;
    localparam int IRQ_TOFF  = 0;
    localparam int IRQ_TOACK = 1;
    localparam int IRQ_PME   = 2;
    localparam int IRQ_CTRLS = 3;
    // Report layout
    localparam int RPT_W     = 10;
    localparam int RPT_DLO   = 2;
    localparam int RPT_DHI   = 9;
    localparam logic [1:0] SCALE_UNKNOWN = 2'h0;
    // Reset values
    localparam logic [31:0] ZERO32 = 32'h00000000;
    localparam logic [3:0]  CTRL_RST = 4'h0;
    localparam logic [IRQ_W-1:0] IRQ_RST = 4'h0;
    // Message kinds toward the link
    typedef enum logic [1:0] {
        MSG_NONE, MSG_TURNOFF, MSG_TOACK, MSG_PME
    } pmsb_msg_t;
endpackage : pmsb_pkg

//--- tb/pmsb_link_model.sv
// Purpose: Link partner model for the power-management sideband
// Assumes: One clock mclk, synchronous active-high reset
// Notes:   Accepts messages after a random stall; wakes on request
`timescale 1ns/1ns
`default_nettype none
module pmsb_link_model (
    // Clock and reset
    input  wire logic       mclk,
    input  wire logic       reset,
    // Bench requests: received messages and entry to low power
    input  wire logic       injTurnoff,
    input  wire logic       injToAck,
    input  wire logic       goLowPower,
    // From the block
    input  wire logic       linkWakeReq,
    input  wire logic       msgValid,
    input  wire logic [1:0] msgKind,
    // To the block
    output logic            linkTurnoffRx,
    output logic            linkToAckRx,
    output logic            linkLowPower,
    output logic            linkWakeDone,
    output logic            msgAccept
);
    int         msgCount   = 0;
    int         pmeWhileLow = 0;
    int         wakeDly    = 0;
    logic [1:0] lastKind   = 2'h0;
    // Stalls a random time so the block must hold its request; one driver per output
    always @(posedge mclk) begin
        linkWakeDone  <= 1'b0;
        msgAccept     <= 1'b0;
        linkTurnoffRx <= injTurnoff & ~reset;
        linkToAckRx   <= injToAck & ~reset;
        if (reset) begin
            linkLowPower <= 1'b0;
            wakeDly      <= 0;
        end else begin
            if (goLowPower) linkLowPower <= 1'b1;
            if (linkWakeReq && !linkWakeDone) begin
                wakeDly <= wakeDly + 1;
                if (wakeDly == 3) begin
                    linkLowPower <= 1'b0;
                    linkWakeDone <= 1'b1;
                    wakeDly      <= 0;
                end
            end
            if (msgValid && !msgAccept && $urandom_range(0, 2) == 0) msgAccept <= 1'b1;
            // PME must not leave while link sleeps
            if (msgValid && msgAccept) begin
                msgCount <= msgCount + 1;
                lastKind <= msgKind;
                if (msgKind == 2'h3 && linkLowPower) pmeWhileLow <= pmeWhileLow + 1;
            end
        end
    end
endmodule : pmsb_link_model
`default_nettype wire

//--- tb/testbench.sv
// Purpose: Self-checking bench for the power-management sideband
// Assumes: prdata and pslverr are taken at the edge where pready is high
// Notes:   Random report values and aux bits from a fixed seed
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, e) begin n_compared++; if ((a) !== (e)) begin fail_count++; \
    $display("[ERR] %0t got %h exp %h", $time, a, e); end end
module testbench;
    logic mclk = 0, reset = 1, psel = 0, penable = 0, pwrite = 0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h00000000, prdata, rd;
    logic pready, pslverr, err, tfc = 0, per = 0, aux = 0, pulseOut, irq, wake, mv, acc;
    logic [9:0] rpt = 10'h000;
    logic [1:0] mk, cs;
    logic [7:0] cv;
    logic tRx, aRx, lowP, wDone;
    logic injT = 0, injA = 0, sleep = 0;
    int fail_count = 0, n_compared = 0, pulses = 0, cycles = 0, base;
    always #25 mclk = ~mclk;
    pmsb_sideband i_dut (.mclk(mclk), .reset(reset), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
        .pslverr(pslverr), .turnoffControl(tfc), .powerEventRequest(per),
        .powerConsumptionReport(rpt), .auxSupplyIndicator(aux), .turnoffStatusPulse(pulseOut),
        .irq(irq), .linkTurnoffRx(tRx), .linkToAckRx(aRx), .linkLowPower(lowP),
        .linkWakeDone(wDone), .linkWakeReq(wake), .msgValid(mv), .msgKind(mk),
        .msgAccept(acc), .capDataValue(cv), .capDataScale(cs));
    pmsb_link_model i_link (.mclk(mclk), .reset(reset), .injTurnoff(injT), .injToAck(injA),
        .goLowPower(sleep), .linkWakeReq(wake), .msgValid(mv),
        .msgKind(mk), .linkTurnoffRx(tRx), .linkToAckRx(aRx), .linkLowPower(lowP),
        .linkWakeDone(wDone), .msgAccept(acc));
    // Count status pulse cycles and bound the run
    always @(posedge mclk) begin
        if (pulseOut === 1'b1) pulses++;
        cycles++;
        if (cycles == 20000) begin fail_count++; complete_run(); end
    end
    task automatic complete_run();
        $display("compared %0d mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : complete_run
    // One APB transfer; data taken at the pready edge, only the timeout ends the wait
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
        @(posedge mclk);
        {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, wr, a, wd};
        @(posedge mclk) penable <= 1'b1;
        do @(posedge mclk); while (pready !== 1'b1);
        rd  = prdata;
        err = pslverr;
        {psel, penable} <= 2'h0;
    endtask : apb
    // Inject one received message through the link model
    task automatic linkPulse(input logic ack);
        @(posedge mclk);
        if (ack) injA <= 1'b1;
        else injT <= 1'b1;
        @(posedge mclk);
        {injA, injT} <= 2'h0;
    endtask : linkPulse
    // Wait for the model to take the n-th message
    task automatic waitMsgs(input int n);
        repeat (60) if (i_link.msgCount < n) @(posedge mclk);
    endtask : waitMsgs
    // Report reaches capability fields only with aux current zero
    function automatic logic [9:0] expCap(input logic [9:0] r, input logic [2:0] a);
        return (a == 3'h0) ? r : 10'h000;
    endfunction : expCap
    initial begin
        void'($urandom(32'h0b66f8ae));
        repeat (8) @(posedge mclk);
        reset <= 1'b0;
        // Reset values, unmapped place, aux indicator
        aux <= 1'($urandom);
        apb(0, pmsb_pkg::ADDR_CTRL, 0);     `CHK(rd, pmsb_pkg::ZERO32)
        apb(0, pmsb_pkg::ADDR_STATUS, 0);   `CHK(rd[pmsb_pkg::ST_AUX], aux)
        apb(0, 12'h020, 0);                 `CHK(err, 1'b1)
        apb(1, pmsb_pkg::ADDR_IRQMASK, 32'h0000000F);
        $display("test regs done");
        // Endpoint turn-off, then held acknowledge gives one message
        base = pulses;
        linkPulse(1'b0);
        repeat (4) @(posedge mclk);
        `CHK(pulses - base, 1)
        `CHK(irq, 1'b1)
        apb(0, pmsb_pkg::ADDR_IRQSTAT, 0);  `CHK(rd[pmsb_pkg::IRQ_TOFF], 1'b1)
        @(posedge mclk);
        `CHK(irq, 1'b0)
        @(posedge mclk) tfc <= 1'b1;
        waitMsgs(1);
        repeat (20) @(posedge mclk);
        `CHK(i_link.msgCount, 1)
        `CHK(i_link.lastKind, pmsb_pkg::MSG_TOACK)
        tfc <= 1'b0;
        $display("test endpoint done");
        // PME from low power wakes the link first, twice over
        for (int k = 2; k <= 3; k++) begin
            @(posedge mclk) sleep <= 1'b1;
            @(posedge mclk) sleep <= 1'b0;
            per <= 1'b1;
            waitMsgs(k);
            `CHK(i_link.lastKind, pmsb_pkg::MSG_PME)
            per <= 1'b0;
        end
        `CHK(i_link.pmeWhileLow, 0)
        $display("test pme done");
        // Root role: turn-off out, acknowledge in, no PME input
        apb(1, pmsb_pkg::ADDR_CTRL, 32'h00000001);
        @(posedge mclk) tfc <= 1'b1;
        waitMsgs(4);
        `CHK(i_link.lastKind, pmsb_pkg::MSG_TURNOFF)
        tfc <= 1'b0;
        base = pulses;
        linkPulse(1'b1);
        @(posedge mclk) per <= 1'b1;
        repeat (20) @(posedge mclk);
        `CHK(pulses - base, 1)
        `CHK(i_link.msgCount, 4)
        per <= 1'b0;
        $display("test root done");
        // Report with every scale code, aux bits zero or not
        for (int i = 0; i < 8; i++) begin
            logic [2:0] a;
            a = i[2] ? 3'($urandom_range(1, 7)) : 3'h0;
            rpt <= {8'($urandom), i[1:0]};
            apb(1, pmsb_pkg::ADDR_CTRL, {28'h0000000, a, 1'b0});
            repeat (3) @(posedge mclk);
            `CHK({cv, cs}, expCap(rpt, a))
            apb(0, pmsb_pkg::ADDR_REPORT, 0);  `CHK(rd[9:0], expCap(rpt, a))
        end
        $display("test report done");
        complete_run();
    end
endmodule : testbench
`default_nettype wire
